// ===== verilog/scc_top.v
// system clock controller: source switching, prescalers, gating, guard
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "scc_defs.vh"
module scc_top (
   // clock, reset, enable
   input wire clk_sys,
   input wire reset_n,
   input wire clk_en,
   // register port
   input wire [2:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   // oscillator status and sampled clocks
   input wire [5:0] osc_rdy_pin,
   input wire [4:0] osc_clk_pin,
   input wire wdg_run,
   // oscillator and pll controls
   output reg [4:0] osc_en,
   output reg pll_en_o,
   output reg pll_src_o,
   output reg [2:0] msi_range_o,
   output reg [7:0] msi_trim_o,
   // clock tree controls
   output reg [1:0] sys_sel_o,
   output reg [3:0] ahb_div_o,
   output reg [2:0] apb1_div_o,
   output reg [2:0] apb2_div_o,
   output reg [15:0] gate_o,
   output reg [1:0] rtc_sel_o,
   output reg [2:0] mco_sel_o,
   output reg mco_en_o,
   output reg usb_clk_en_o,
   // interrupt
   output reg irq
);
   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   localparam ST_IDLE = 2'h0; // running on the active source
   localparam ST_WAIT = 2'h1; // new source starting up
   localparam ST_SWAP = 2'h2; // both running, mux settling
   localparam [15:0] GUARD_CYC = `SCC_GUARD_CYC;
   localparam [7:0] SWAP_CYC = `SCC_SWAP_CYC;
   reg [1:0] rst_sync_reg; // reset release synchroniser
   wire rst_n;
   reg [5:0] rdy_s1_reg, rdy_s2_reg; // ready level synchroniser
   reg [4:0] ck_s1_reg, ck_s2_reg, ck_s3_reg; // clock pin sampler
   wire [4:0] ck_tick; // rising edge of each sampled clock
   reg [31:0] ctrl_reg; // control fields
   reg [9:0] presc_reg; // prescaler codes
   reg [15:0] gate_reg; // clock gates
   reg [3:0] flag_reg, mask_reg; // interrupt status and mask
   reg [7:0] trim_reg; // multispeed trim
   reg [2:0] meas_cfg_reg; // measurement selectors
   reg meas_start_reg; // measurement start pulse
   reg [1:0] state_reg; // switch sequencer
   reg [1:0] act_src_reg, req_src_reg; // driven and requested source
   reg [7:0] swap_cnt_reg; // settle count
   reg [15:0] idle_cnt_reg; // cycles since last crystal edge
   reg cfg_err_reg; // last control or prescaler write refused
   wire meas_busy, meas_done;
   wire [15:0] meas_count;
   wire ref_tick, tgt_tick;
   wire [1:0] wr_src;
   wire wr_ok, wr_presc_ok, guard_fail, hse_used;
   wire [3:0] flag_set;

   // ----------------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------------
   // frequency of a system source in kHz
   function [31:0] src_khz;
      input [1:0] src;
      input [2:0] rng;
      begin
         case (src)
            `SCC_SRC_MULTI: begin
               case (rng)
                  3'h0: src_khz = 32'd65;
                  3'h1: src_khz = 32'd131;
                  3'h2: src_khz = 32'd262;
                  3'h3: src_khz = 32'd524;
                  3'h4: src_khz = 32'd1050;
                  3'h5: src_khz = 32'd2100;
                  default: src_khz = 32'd4200;
               endcase
            end
            `SCC_SRC_INT_FAST: src_khz = `SCC_KHZ_INT_FAST;
            `SCC_SRC_EXT_FAST: src_khz = `SCC_KHZ_EXT_FAST;
            default: src_khz = `SCC_KHZ_PLL_SYS;
         endcase
      end
   endfunction

   // true when a bus setting stays within the limit
   function bus_ok;
      input [1:0] src;
      input [2:0] rng;
      input [3:0] div;
      begin
         bus_ok = (src_khz(src, rng) >> div) <= `SCC_KHZ_BUS_MAX;
      end
   endfunction

   // ----------------------------------------------------------------------
   // reset release and input synchronisers
   // ----------------------------------------------------------------------
   // asynchronous assert, release two clocks later
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // oscillator pins come from other domains
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdy_s1_reg <= 6'h00;
         rdy_s2_reg <= 6'h00;
         ck_s1_reg <= 5'h00;
         ck_s2_reg <= 5'h00;
         ck_s3_reg <= 5'h00;
      end else if (clk_en) begin
         rdy_s1_reg <= osc_rdy_pin;
         rdy_s2_reg <= rdy_s1_reg;
         ck_s1_reg <= osc_clk_pin;
         ck_s2_reg <= ck_s1_reg;
         ck_s3_reg <= ck_s2_reg;
      end
   end
   assign ck_tick = ck_s2_reg & ~ck_s3_reg;

   // ----------------------------------------------------------------------
   // decode of writes and guard
   // ----------------------------------------------------------------------
   assign wr_src = reg_wdata[`SCC_CTRL_SRC_LSB+1:`SCC_CTRL_SRC_LSB];
   // refuse a source that would overclock the bus
   assign wr_ok = bus_ok(wr_src,
      reg_wdata[`SCC_CTRL_RNG_LSB+2:`SCC_CTRL_RNG_LSB],
      presc_reg[3:0]) && reg_wdata[`SCC_CTRL_RNG_LSB+2:`SCC_CTRL_RNG_LSB]
      != 3'h7;
   assign wr_presc_ok = bus_ok(act_src_reg, ctrl_reg[12:10],
      reg_wdata[3:0]) && bus_ok(req_src_reg, ctrl_reg[12:10],
      reg_wdata[3:0]);
   assign hse_used = act_src_reg == `SCC_SRC_EXT_FAST
      || (act_src_reg == `SCC_SRC_PLL && ctrl_reg[`SCC_CTRL_PLL_SRC]);
   assign guard_fail = ctrl_reg[`SCC_CTRL_GUARD] && hse_used
      && idle_cnt_reg >= GUARD_CYC;

   // crystal activity watchdog, only while it is in use
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         idle_cnt_reg <= 16'h0000;
      end else if (clk_en) begin
         if (!hse_used || ck_tick[`SCC_OSC_EXT_FAST] || guard_fail) begin
            idle_cnt_reg <= 16'h0000;
         end else begin
            idle_cnt_reg <= idle_cnt_reg + 16'h0001;
         end
      end
   end

   // ----------------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------------
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= {13'h0000, 1'b0, 3'h0, 2'h0, `SCC_RST_RANGE,
            `SCC_SRC_MULTI, 3'h0, `SCC_RST_OSC_EN};
         presc_reg <= 10'h000;
         gate_reg <= `SCC_RST_GATE;
         mask_reg <= 4'h0;
         trim_reg <= `SCC_RST_TRIM;
         meas_cfg_reg <= 3'h0;
         meas_start_reg <= 1'b0;
         cfg_err_reg <= 1'b0;
      end else if (clk_en) begin
         meas_start_reg <= 1'b0;
         if (guard_fail) begin
            // crystal gone: drop it and the pll fed by it
            ctrl_reg[`SCC_CTRL_OSC_LSB+`SCC_OSC_EXT_FAST] <= 1'b0;
            ctrl_reg[`SCC_CTRL_OSC_LSB+`SCC_OSC_INT_FAST] <= 1'b1;
            if (ctrl_reg[`SCC_CTRL_PLL_SRC]) begin
               ctrl_reg[`SCC_CTRL_PLL_EN] <= 1'b0;
            end
            ctrl_reg[`SCC_CTRL_SRC_LSB+1:`SCC_CTRL_SRC_LSB]
               <= `SCC_SRC_INT_FAST;
         end else if (reg_wr) begin
            case (reg_addr)
               `SCC_OFF_CTRL: begin
                  // no new request while a switch is in flight
                  if (wr_ok && state_reg == ST_IDLE) begin
                     ctrl_reg <= {13'h0000, reg_wdata[18:0]};
                     cfg_err_reg <= 1'b0;
                  end else begin
                     cfg_err_reg <= 1'b1;
                  end
               end
               `SCC_OFF_PRESC: begin
                  if (wr_presc_ok) begin
                     presc_reg <= reg_wdata[9:0];
                     cfg_err_reg <= 1'b0;
                  end else begin
                     cfg_err_reg <= 1'b1;
                  end
               end
               `SCC_OFF_GATE: gate_reg <= reg_wdata[15:0];
               `SCC_OFF_MASK: mask_reg <= reg_wdata[3:0];
               `SCC_OFF_MEAS: begin
                  meas_cfg_reg <= reg_wdata[2:0];
                  meas_start_reg <= reg_wdata[0];
               end
               `SCC_OFF_TRIM: trim_reg <= reg_wdata[7:0];
               default: begin
                  cfg_err_reg <= cfg_err_reg;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // source switch sequencer
   // ----------------------------------------------------------------------
   // stable means ready; pll also needs its input ready
   function src_stable;
      input [1:0] src;
      input [5:0] rdy;
      input pll_src;
      begin
         case (src)
            `SCC_SRC_MULTI: src_stable = rdy[`SCC_OSC_MULTI];
            `SCC_SRC_INT_FAST: src_stable = rdy[`SCC_OSC_INT_FAST];
            `SCC_SRC_EXT_FAST: src_stable = rdy[`SCC_OSC_EXT_FAST];
            default: src_stable = rdy[`SCC_OSC_PLL_LOCK]
               && rdy[pll_src ? `SCC_OSC_EXT_FAST : `SCC_OSC_INT_FAST];
         endcase
      end
   endfunction

   // old source stays on until the mux has moved
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         act_src_reg <= `SCC_SRC_MULTI;
         req_src_reg <= `SCC_SRC_MULTI;
         swap_cnt_reg <= 8'h00;
      end else if (clk_en) begin
         if (guard_fail) begin
            // no waiting: the failed source gives no clock anyway
            state_reg <= ST_IDLE;
            act_src_reg <= `SCC_SRC_INT_FAST;
            req_src_reg <= `SCC_SRC_INT_FAST;
         end else begin
            case (state_reg)
               ST_IDLE: begin
                  if (reg_wr && reg_addr == `SCC_OFF_CTRL && wr_ok
                      && wr_src != act_src_reg) begin
                     req_src_reg <= wr_src;
                     state_reg <= ST_WAIT;
                  end
               end
               ST_WAIT: begin
                  if (src_stable(req_src_reg, rdy_s2_reg,
                      ctrl_reg[`SCC_CTRL_PLL_SRC])) begin
                     state_reg <= ST_SWAP;
                     swap_cnt_reg <= SWAP_CYC;
                  end
               end
               ST_SWAP: begin
                  if (swap_cnt_reg == 8'h00) begin
                     act_src_reg <= req_src_reg;
                     state_reg <= ST_IDLE;
                  end else begin
                     swap_cnt_reg <= swap_cnt_reg - 8'h01;
                  end
               end
               default: state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // measurement unit
   // ----------------------------------------------------------------------
   // ref: slow rc or slow crystal; target: fast rc or multispeed
   assign ref_tick = meas_cfg_reg[1] ? ck_tick[`SCC_OSC_EXT_SLOW]
      : ck_tick[`SCC_OSC_INT_SLOW];
   assign tgt_tick = meas_cfg_reg[2] ? ck_tick[`SCC_OSC_MULTI]
      : ck_tick[`SCC_OSC_INT_FAST];
   scc_meas u_meas (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .start(meas_start_reg),
      .ref_tick(ref_tick),
      .tgt_tick(tgt_tick),
      .busy(meas_busy),
      .done(meas_done),
      .count(meas_count)
   );

   // ----------------------------------------------------------------------
   // interrupt flags
   // ----------------------------------------------------------------------
   assign flag_set = {reg_wr && cfg_refused(reg_addr), meas_done,
      state_reg == ST_SWAP && swap_cnt_reg == 8'h00, guard_fail};

   // write-one-to-clear; a new event in the same cycle wins
   function cfg_refused;
      input [2:0] a;
      begin
         cfg_refused = (a == `SCC_OFF_CTRL
            && !(wr_ok && state_reg == ST_IDLE))
            || (a == `SCC_OFF_PRESC && !wr_presc_ok);
      end
   endfunction

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         flag_reg <= 4'h0;
         irq <= 1'b0;
      end else if (clk_en) begin
         if (reg_wr && reg_addr == `SCC_OFF_IRQ && !guard_fail) begin
            flag_reg <= (flag_reg & ~reg_wdata[3:0]) | flag_set;
         end else begin
            flag_reg <= flag_reg | flag_set;
         end
         irq <= |(flag_reg & mask_reg);
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   // every output is a flop; enables keep both sources during a swap
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         osc_en <= `SCC_RST_OSC_EN;
         pll_en_o <= 1'b0;
         pll_src_o <= 1'b0;
         msi_range_o <= `SCC_RST_RANGE;
         msi_trim_o <= `SCC_RST_TRIM;
         sys_sel_o <= `SCC_SRC_MULTI;
         ahb_div_o <= 4'h0;
         apb1_div_o <= 3'h0;
         apb2_div_o <= 3'h0;
         gate_o <= `SCC_RST_GATE;
         rtc_sel_o <= 2'h0;
         mco_sel_o <= 3'h0;
         mco_en_o <= 1'b0;
         usb_clk_en_o <= 1'b0;
      end else if (clk_en) begin
         osc_en <= ctrl_reg[4:0]
            | src_bit(act_src_reg) | src_bit(req_src_reg)
            | {wdg_run || meas_busy || rtc_sel_o == 2'h1, 1'b0,
               meas_busy && meas_cfg_reg[2], 2'h0};
         pll_en_o <= ctrl_reg[`SCC_CTRL_PLL_EN];
         pll_src_o <= ctrl_reg[`SCC_CTRL_PLL_SRC];
         msi_range_o <= ctrl_reg[12:10];
         msi_trim_o <= trim_reg;
         sys_sel_o <= act_src_reg;
         ahb_div_o <= presc_reg[3:0];
         apb1_div_o <= presc_reg[6:4];
         apb2_div_o <= presc_reg[9:7];
         gate_o <= gate_reg;
         rtc_sel_o <= ctrl_reg[14:13];
         mco_sel_o <= ctrl_reg[17:15];
         mco_en_o <= ctrl_reg[`SCC_CTRL_MCO_EN];
         usb_clk_en_o <= ctrl_reg[`SCC_CTRL_PLL_EN]
            && rdy_s2_reg[`SCC_OSC_PLL_LOCK];
      end
   end

   // oscillators a system source needs running
   function [4:0] src_bit;
      input [1:0] s;
      begin
         case (s)
            `SCC_SRC_MULTI: src_bit = 5'h04;
            `SCC_SRC_INT_FAST: src_bit = 5'h02;
            `SCC_SRC_EXT_FAST: src_bit = 5'h01;
            default: src_bit = ctrl_reg[`SCC_CTRL_PLL_SRC] ? 5'h01
               : 5'h02;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------------
   // register read, data in the following cycle only
   // ----------------------------------------------------------------------
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (clk_en) begin
         reg_rdata <= 32'h0000_0000;
         if (reg_rd) begin
            case (reg_addr)
               `SCC_OFF_CTRL: reg_rdata <= ctrl_reg;
               `SCC_OFF_PRESC: reg_rdata <= {22'h000000, presc_reg};
               `SCC_OFF_GATE: reg_rdata <= {16'h0000, gate_reg};
               `SCC_OFF_STAT: begin
                  // usb ready only with crystal-fed pll as source
                  reg_rdata <= {18'h00000, cfg_err_reg, meas_busy,
                     act_src_reg == `SCC_SRC_PLL
                     && ctrl_reg[`SCC_CTRL_PLL_SRC]
                     && rdy_s2_reg[`SCC_OSC_PLL_LOCK],
                     rdy_s2_reg, state_reg != ST_IDLE, req_src_reg,
                     act_src_reg};
               end
               `SCC_OFF_IRQ: reg_rdata <= {28'h0000000, flag_reg};
               `SCC_OFF_MASK: reg_rdata <= {28'h0000000, mask_reg};
               `SCC_OFF_MEAS: reg_rdata <= {13'h0000, meas_cfg_reg,
                  meas_count};
               default: reg_rdata <= {24'h000000, trim_reg};
            endcase
         end
      end
   end
endmodule // scc_top
`default_nettype wire

// ===== verilog/scc_defs.vh
// constants shared by the system clock controller files
`ifndef SCC_DEFS_VH
`define SCC_DEFS_VH
// ----------------------------------------------------------------------
// register word offsets
// ----------------------------------------------------------------------
`define SCC_OFF_CTRL 3'h0
`define SCC_OFF_PRESC 3'h1
`define SCC_OFF_GATE 3'h2
`define SCC_OFF_STAT 3'h3
`define SCC_OFF_IRQ 3'h4
`define SCC_OFF_MASK 3'h5
`define SCC_OFF_MEAS 3'h6
`define SCC_OFF_TRIM 3'h7
// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define SCC_CTRL_OSC_LSB 0
`define SCC_CTRL_PLL_EN 5
`define SCC_CTRL_PLL_SRC 6
`define SCC_CTRL_GUARD 7
`define SCC_CTRL_SRC_LSB 8
`define SCC_CTRL_RNG_LSB 10
`define SCC_CTRL_RTC_LSB 13
`define SCC_CTRL_MCO_LSB 15
`define SCC_CTRL_MCO_EN 18
// ----------------------------------------------------------------------
// oscillator indices and system source codes
// ----------------------------------------------------------------------
`define SCC_OSC_EXT_FAST 0
`define SCC_OSC_INT_FAST 1
`define SCC_OSC_MULTI 2
`define SCC_OSC_EXT_SLOW 3
`define SCC_OSC_INT_SLOW 4
`define SCC_OSC_PLL_LOCK 5
`define SCC_SRC_MULTI 2'h0
`define SCC_SRC_INT_FAST 2'h1
`define SCC_SRC_EXT_FAST 2'h2
`define SCC_SRC_PLL 2'h3
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SCC_RST_OSC_EN 5'h04
`define SCC_RST_RANGE 3'h5
`define SCC_RST_TRIM 8'h80
`define SCC_RST_GATE 16'hffff
// ----------------------------------------------------------------------
// frequencies in kHz and timing
// ----------------------------------------------------------------------
`define SCC_KHZ_INT_FAST 32'd16000
`define SCC_KHZ_PLL_SYS 32'd32000
`define SCC_KHZ_EXT_FAST 32'd8000
`define SCC_KHZ_BUS_MAX 32'd32000
`define SCC_CLK_NS 10
`define SCC_GUARD_NS 2000
`define SCC_GUARD_CYC (`SCC_GUARD_NS / `SCC_CLK_NS)
`define SCC_SWAP_NS 100
`define SCC_SWAP_CYC (`SCC_SWAP_NS / `SCC_CLK_NS)
`define SCC_MEAS_PERIODS 16
`endif

// ===== verilog/scc_meas.v
// frequency measurement counter for the system clock controller
`timescale 1ns/10ps
`default_nettype none
`include "scc_defs.vh"
module scc_meas (
   // clock, reset, enable
   input wire clk_sys,
   input wire rst_n,
   input wire clk_en,
   // control
   input wire start,
   input wire ref_tick,
   input wire tgt_tick,
   // result
   output reg busy,
   output reg done,
   output reg [15:0] count
);
   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   localparam ST_IDLE = 2'h0; // waiting for start
   localparam ST_ARM = 2'h1; // waiting for first reference edge
   localparam ST_RUN = 2'h2; // counting target edges
   localparam [4:0] PERIODS = `SCC_MEAS_PERIODS;
   reg [1:0] state_reg;
   reg [4:0] ref_cnt_reg; // reference periods seen
   reg [15:0] tgt_cnt_reg; // target edges seen

   // window opens on a reference edge so the gate is whole periods
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         ref_cnt_reg <= 5'h00;
         tgt_cnt_reg <= 16'h0000;
         busy <= 1'b0;
         done <= 1'b0;
         count <= 16'h0000;
      end else if (clk_en) begin
         done <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (start) begin
                  state_reg <= ST_ARM;
                  busy <= 1'b1;
               end
            end
            ST_ARM: begin
               if (ref_tick) begin
                  state_reg <= ST_RUN;
                  ref_cnt_reg <= 5'h00;
                  tgt_cnt_reg <= 16'h0000;
               end
            end
            ST_RUN: begin
               // saturate rather than wrap on a too-fast target
               if (tgt_tick && tgt_cnt_reg != 16'hffff) begin
                  tgt_cnt_reg <= tgt_cnt_reg + 16'h0001;
               end
               if (ref_tick) begin
                  ref_cnt_reg <= ref_cnt_reg + 5'h01;
                  if (ref_cnt_reg == PERIODS - 5'h01) begin
                     state_reg <= ST_IDLE;
                     busy <= 1'b0;
                     done <= 1'b1;
                     count <= tgt_cnt_reg;
                  end
               end
            end
            default: begin
               state_reg <= ST_IDLE;
               busy <= 1'b0;
            end
         endcase
      end
   end
endmodule // scc_meas
`default_nettype wire

// ===== tb/scc_osc_model.sv
// oscillator and pll stand-in for the clock controller's far side
`timescale 1ns/10ps
`default_nettype none
module scc_osc_model (
   // clock and fault command
   input wire logic clk_sys,
   input wire logic xtal_dead,
   // controls from the controller
   input wire logic [4:0] osc_en,
   input wire logic pll_en_o,
   // status and clocks back
   output logic [5:0] osc_rdy_pin,
   output logic [4:0] osc_clk_pin
);
   logic [6:0] cnt = 7'h0; // free divider for the fake oscillators
   logic [5:0] rdy_reg = 6'h0; // ready lags enable by one cycle
   // a dead crystal stops toggling and drops its ready
   always @(posedge clk_sys) begin
      cnt <= cnt + 7'h1;
      rdy_reg <= {pll_en_o & (osc_en[0] | osc_en[1]), osc_en}
         & {5'h1f, !xtal_dead};
   end
   assign osc_rdy_pin = rdy_reg;
   // slow ones use high divider bits, the crystal toggles every cycle
   assign osc_clk_pin = osc_en & {cnt[6], cnt[5], cnt[2], cnt[1],
      cnt[0] & !xtal_dead};
endmodule // scc_osc_model
`default_nettype wire

// ===== tb/scc_top_sva.sv
// assertion checker for the system clock controller ports
`timescale 1ns/10ps
`default_nettype none
module scc_top_sva (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // watched ports
   input wire logic clk_en, reg_rd, reg_wr, wdg_run, pll_en_o, usb_clk_en_o,
   input wire logic [2:0] reg_addr, msi_range_o,
   input wire logic [31:0] reg_wdata, reg_rdata,
   input wire logic [5:0] osc_rdy_pin,
   input wire logic [4:0] osc_clk_pin, osc_en,
   input wire logic [1:0] sys_sel_o,
   input wire logic [15:0] gate_o
);
   logic xprev; // last sampled crystal level
   logic [8:0] gcnt; // cycles without a crystal edge while it drives
   // counter saturates so a stuck crystal cannot wrap back to zero
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         xprev <= 1'b0;
         gcnt <= 9'h0;
      end else begin
         xprev <= osc_clk_pin[0];
         if (sys_sel_o != 2'h2 || (osc_clk_pin[0] && !xprev)) gcnt <= 9'h0;
         else if (gcnt != 9'h1ff) gcnt <= gcnt + 9'h1;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   property p_rst_src; $rose(reset_n) |-> ##2 sys_sel_o == 2'h0 &&
      msi_range_o == 3'h5; endproperty
   a_rst_src: assert property (p_rst_src) else $error("bad start clock");
   property p_rng; msi_range_o != 3'h7; endproperty
   a_rng: assert property (p_rng) else $error("range code 7 taken");
   property p_new_rdy; $changed(sys_sel_o) && sys_sel_o == 2'h2 |->
      osc_rdy_pin[0]; endproperty
   a_new_rdy: assert property (p_new_rdy) else $error("unready swap");
   property p_usb; usb_clk_en_o |-> $past(pll_en_o); endproperty
   a_usb: assert property (p_usb) else $error("usb clock without pll");
   property p_rd_idle; $past(clk_en) && !$past(reg_rd) |->
      reg_rdata == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
   property p_gate; clk_en && reg_wr && reg_addr == 3'h2 ##1 clk_en ##1
      clk_en |-> gate_o == $past(reg_wdata[15:0], 2); endproperty
   a_gate: assert property (p_gate) else $error("gate not applied");
   property p_wdg; wdg_run [*5] |-> osc_en[4]; endproperty
   a_wdg: assert property (p_wdg) else $error("slow rc off for dog");
   property p_guard; gcnt < 9'd240; endproperty
   a_guard: assert property (p_guard) else $error("no crystal fallback");
endmodule // scc_top_sva
bind scc_top scc_top_sva i_sva (.*);
`default_nettype wire

// ===== tb/scc_top_tb_top.sv
// self-checking bench for the system clock controller
`timescale 1ns/10ps
`default_nettype none
module scc_top_tb_top;
   logic clk_sys, reset_n, reg_wr, reg_rd, wdg_run, xtal_dead;
   logic clk_en = 1'b1; // dropped once to check the freeze
   logic [2:0] reg_addr, msi_range_o, apb1_div_o, apb2_div_o, mco_sel_o;
   logic [31:0] reg_wdata, reg_rdata, rd_val;
   logic [5:0] osc_rdy_pin;
   logic [4:0] osc_clk_pin, osc_en;
   logic pll_en_o, pll_src_o, usb_clk_en_o, irq, mco_en_o;
   logic [1:0] sys_sel_o, rtc_sel_o;
   logic [7:0] msi_trim_o;
   logic [15:0] gate_o;
   logic [3:0] ahb_div_o;
   int miscompares = 0, tests_run = 0;
   // address, write data, expected read back
   logic [66:0] rows [4] = '{{3'h2, 32'ha5c3, 32'ha5c3},
      {3'h7, 32'h3c, 32'h3c}, {3'h5, 32'hf, 32'hf}, {3'h1, 32'h1c9, 32'h1c9}};
   scc_top i_dut (.*);
   scc_osc_model i_osc (.*);
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, e);
      tests_run++;
      if (g !== e) begin
         $display("Error at %0t: got %h expected %h", $time, g, e);
         miscompares++;
      end
   endtask
   // one-cycle strobes, changed just after the edge
   task automatic wr(input logic [2:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a);
      @(posedge clk_sys);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
      rd_val = reg_rdata;
   endtask
   // bounded wait for the master select
   task automatic wsel(input logic [1:0] s);
      int n = 0;
      while (sys_sel_o !== s && n < 600) begin @(posedge clk_sys); n++; end
      if (n >= 600) begin miscompares++; close_out(); end
   endtask
   initial begin
      reset_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 3'h0;
      reg_wdata = 32'h0; wdg_run = 1'b0; xtal_dead = 1'b0;
      repeat (6) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk({sys_sel_o, msi_range_o, msi_trim_o, gate_o}, 29'h0580ffff);
      foreach (rows[i]) begin
         wr(rows[i][66:64], rows[i][63:32]);
         rd(rows[i][66:64]);
         chk(rd_val, rows[i][31:0]);
      end
      chk({msi_trim_o, gate_o}, 24'h3ca5c3);
      chk({apb2_div_o, apb1_div_o, ahb_div_o}, 10'h1c9);
      // a write while the enable is low must not land
      clk_en <= 1'b0;
      wr(3'h2, 32'h1234);
      clk_en <= 1'b1;
      rd(3'h2);
      chk(rd_val, 32'ha5c3);
      // every range, then code 7 must be refused
      for (int r = 0; r < 8; r++) begin
         wr(3'h0, 32'h4 | (r << 10));
         repeat (2) @(posedge clk_sys);
         chk(msi_range_o, (r == 7) ? 3'h6 : r);
      end
      rd(3'h4);
      chk({irq, rd_val[3]}, 2'b11);
      wr(3'h4, 32'hf);
      wr(3'h5, 32'h1);
      repeat (3) @(posedge clk_sys);
      chk(irq, 1'b0);
      wr(3'h0, 32'h1685);
      wsel(2'h2);
      xtal_dead <= 1'b1;
      wsel(2'h1);
      repeat (3) @(posedge clk_sys);
      chk({irq, osc_en[1:0]}, 3'b110);
      xtal_dead <= 1'b0;
      wr(3'h4, 32'hf);
      wr(3'h0, 32'h5d76f);
      wsel(2'h3);
      wdg_run <= 1'b1;
      repeat (8) @(posedge clk_sys);
      chk({usb_clk_en_o, irq, osc_en[4]}, 3'b101);
      chk({rtc_sel_o, mco_sel_o, mco_en_o}, 6'b100111);
      chk({pll_en_o, pll_src_o}, 2'b11);
      // 16 slow periods of 128 cycles, a fast rc edge every 4
      wr(3'h6, 32'h1);
      repeat (2300) @(posedge clk_sys);
      rd(3'h6);
      chk(rd_val, 32'h10200);
      rd(3'h4);
      chk(rd_val, 32'h6);
      // mid-run reset brings back the start clock
      reset_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk({sys_sel_o, msi_range_o, msi_trim_o, gate_o}, 29'h0580ffff);
      close_out();
   end
endmodule // scc_top_tb_top
`default_nettype wire
